// File: logic/dac_serial_load_control.sv
// dual converter load control: serial frame capture, commit, and axi4-lite status
// assumes aclk at 100 MHz, shift clock at most 25 MHz and unrelated in phase
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module dac_serial_load_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [dac_link_pkg::ADDR_BITS-1:0] awaddr,
	input wire logic awvalid,
	output var logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output var logic wready,
	output var logic [1:0] bresp,
	output var logic bvalid,
	input wire logic bready,
	input wire logic [dac_link_pkg::ADDR_BITS-1:0] araddr,
	input wire logic arvalid,
	output var logic arready,
	output var logic [31:0] rdata,
	output var logic [1:0] rresp,
	output var logic rvalid,
	input wire logic rready,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdata,
	output var logic [dac_link_pkg::DATA_BITS-1:0] channel_a_output,
	output var logic [dac_link_pkg::DATA_BITS-1:0] channel_b_output,
	output var logic reference_connect_a,
	output var logic reference_connect_b
);
	import dac_link_pkg::*;

	// answer for an address, shared by both bus directions
	function automatic logic [1:0] resp_for(
		input logic [ADDR_BITS-1:0] addr,
		input logic is_write
	);
		logic [1:0] resp;
		resp = RESP_DECERR;
		if (addr[1:0] == 2'h0) begin
			resp = RESP_OKAY;
			if (is_write && addr != CONTROL_OFFSET)
				resp = RESP_SLVERR;
		end
		return resp;
	endfunction : resp_for

	frame_type frame;
	logic frame_full;

	serial_frame_shifter shifter (
		.sclk(sclk),
		.cs_n(cs_n),
		.sdata(sdata),
		.frame(frame),
		.frame_full(frame_full)
	);

	// select crossing into aclk
	logic cs_meta;
	logic cs_sync;
	logic cs_prev;
	logic next_cs_meta;
	logic next_cs_sync;
	logic next_cs_prev;
	logic cs_rise;

	always_comb begin
		next_cs_meta = cs_n;
		next_cs_sync = cs_meta;
		next_cs_prev = cs_sync;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
			cs_prev <= 1'b1;
		end else begin
			cs_meta <= next_cs_meta;
			cs_sync <= next_cs_sync;
			cs_prev <= next_cs_prev;
		end
	end

	// frame and count are quiet here: the shift clock stops once select is high,
	// and 3 aclk cycles fit well inside the select high time at 25 MHz
	assign cs_rise = cs_sync && !cs_prev;

	// commit group
	logic hold;
	logic commit;
	logic short_frame;
	dac_state_type st;
	dac_state_type next_st;
	logic [15:0] frame_count;
	logic [15:0] next_frame_count;
	logic [15:0] short_count;
	logic [15:0] next_short_count;
	logic [FRAME_BITS-1:0] last_frame;
	logic [FRAME_BITS-1:0] next_last_frame;

	assign commit = cs_rise && frame_full && !hold;
	assign short_frame = cs_rise && !frame_full && !hold;

	always_comb begin
		next_st = st;
		next_frame_count = frame_count;
		next_short_count = short_count;
		next_last_frame = last_frame;
		if (commit) begin
			if (frame.load_a)
				next_st.dac_a = frame.data;
			if (frame.load_b)
				next_st.dac_b = frame.data;
			next_st.shutdown_a = frame.shutdown_a;
			next_st.shutdown_b = frame.shutdown_b;
			next_frame_count = frame_count + 16'h0001;
			next_last_frame = frame;
		end
		if (short_frame)
			next_short_count = short_count + 16'h0001;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st.dac_a <= DAC_RESET;
			st.dac_b <= DAC_RESET;
			st.shutdown_a <= 1'b0;
			st.shutdown_b <= 1'b0;
			frame_count <= COUNT_RESET;
			short_count <= COUNT_RESET;
			last_frame <= COUNT_RESET;
		end else begin
			st <= next_st;
			frame_count <= next_frame_count;
			short_count <= next_short_count;
			last_frame <= next_last_frame;
		end
	end

	// output group: registered from the next state, no extra cycle of lag
	logic [DATA_BITS-1:0] next_out_a;
	logic [DATA_BITS-1:0] next_out_b;
	logic next_ref_a;
	logic next_ref_b;

	always_comb begin
		// stored code survives shutdown, only the output drops
		next_out_a = next_st.shutdown_a ? DAC_RESET : next_st.dac_a;
		next_out_b = next_st.shutdown_b ? DAC_RESET : next_st.dac_b;
		next_ref_a = !next_st.shutdown_a;
		next_ref_b = !next_st.shutdown_b;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_a_output <= DAC_RESET;
			channel_b_output <= DAC_RESET;
			reference_connect_a <= 1'b1;
			reference_connect_b <= 1'b1;
		end else begin
			channel_a_output <= next_out_a;
			channel_b_output <= next_out_b;
			reference_connect_a <= next_ref_a;
			reference_connect_b <= next_ref_b;
		end
	end

	// axi write group
	logic aw_full;
	logic w_full;
	logic [ADDR_BITS-1:0] aw_addr;
	logic [31:0] w_data;
	logic w_strb0;
	logic next_aw_full;
	logic next_w_full;
	logic [ADDR_BITS-1:0] next_aw_addr;
	logic [31:0] next_w_data;
	logic next_w_strb0;
	logic next_awready;
	logic next_wready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic next_hold;

	always_comb begin
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb0 = w_strb0;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_hold = hold;
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (awvalid && awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_full = 1'b1;
			next_w_data = wdata;
			next_w_strb0 = wstrb[0];
		end
		if (aw_full && w_full && !bvalid) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = resp_for(aw_addr, 1'b1);
			if (aw_addr == CONTROL_OFFSET && w_strb0)
				next_hold = w_data[HOLD_BIT];
		end
		next_awready = !next_aw_full;
		next_wready = !next_w_full;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= CONTROL_OFFSET;
			w_data <= WORD_RESET;
			w_strb0 <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			hold <= HOLD_RESET;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb0 <= next_w_strb0;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			hold <= next_hold;
		end
	end

	// axi read group
	logic next_arready;
	logic next_rvalid;
	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	always_comb begin
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = resp_for(araddr, 1'b0);
			next_rdata = WORD_RESET;
			unique case (araddr)
				CONTROL_OFFSET: next_rdata[HOLD_BIT] = hold;
				STATUS_OFFSET: begin
					next_rdata[DATA_BITS-1:0] = st.dac_a;
					next_rdata[STATUS_DAC_B_POS +: DATA_BITS] = st.dac_b;
					next_rdata[STATUS_SHUT_A_BIT] = st.shutdown_a;
					next_rdata[STATUS_SHUT_B_BIT] = st.shutdown_b;
				end
				COUNT_OFFSET: begin
					next_rdata[15:0] = frame_count;
					next_rdata[COUNT_SHORT_POS +: 16] = short_count;
				end
				FRAME_OFFSET: next_rdata[FRAME_BITS-1:0] = last_frame;
				default: next_rdata = WORD_RESET;
			endcase
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= WORD_RESET;
			rresp <= RESP_OKAY;
		end else begin
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	load_a_takes_a: assert property (
		commit && frame.load_a |=> st.dac_a == $past(frame.data))
		else $error("channel a did not load the frame data");

	load_b_alone_a: assert property (
		commit && frame.load_b && !frame.load_a |=> $stable(st.dac_a)
			&& st.dac_b == $past(frame.data))
		else $error("channel b load disturbed channel a");

	no_early_load_a: assert property (
		!commit |=> $stable(st))
		else $error("converter state changed outside a select rise");

	shutdown_zero_a: assert property (
		st.shutdown_a |-> channel_a_output == DAC_RESET && !reference_connect_a)
		else $error("shut down channel a still drives or loads reference");

	wake_restores_a: assert property (
		commit && st.shutdown_b && !frame.shutdown_b && !frame.load_b
			|=> channel_b_output == $past(st.dac_b) && reference_connect_b)
		else $error("channel b did not return to stored code");

	short_ignored_a: assert property (
		cs_rise && !frame_full |=> $stable(st) ##1 $stable(st))
		else $error("short frame changed converter state");

	commit_counted_a: assert property (
		commit |=> frame_count == $past(frame_count) + 16'h0001
			&& last_frame == $past(frame))
		else $error("committed frame not recorded");

	reset_clears_a: assert property (@(posedge aclk) disable iff (1'b0)
		!aresetn |=> st.dac_a == DAC_RESET && st.dac_b == DAC_RESET
			&& channel_a_output == DAC_RESET && !st.shutdown_a)
		else $error("reset did not clear converter state");

	bvalid_hold_a: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");

	rvalid_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before taken");

	load_both_c: cover property (commit && frame.load_a && frame.load_b);
	shutdown_c: cover property (commit && frame.shutdown_a && frame.shutdown_b);
	short_frame_c: cover property (short_frame);
	held_frame_c: cover property (cs_rise && hold);

endmodule : dac_serial_load_control

`default_nettype wire

// File: logic/serial_frame_shifter.sv
// shift clock domain: the sixteen-bit input shift register and bit counter
// assumes the shift clock only runs while select is low, frames end with select high
`timescale 1ns/1ps
`default_nettype none

module serial_frame_shifter (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdata,
	output var dac_link_pkg::frame_type frame,
	output var logic frame_full
);
	import dac_link_pkg::*;

	logic [FRAME_BITS-1:0] shift;
	logic [FRAME_BITS-1:0] next_shift;
	logic [4:0] count;
	logic [4:0] next_count;
	logic fresh;

	// shift only while selected, msb first
	always_comb begin
		next_shift = shift;
		next_count = count;
		if (!cs_n) begin
			next_shift = {shift[FRAME_BITS-2:0], sdata};
			if (fresh)
				next_count = 5'h01;
			else if (count != FULL_COUNT)
				next_count = count + 5'h01;
		end
	end

	always_ff @(posedge sclk) begin
		shift <= next_shift;
		count <= next_count;
	end

	// clock stops between frames, so the restart is armed by select itself
	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n)
			fresh <= 1'b1;
		else
			fresh <= 1'b0;
	end

	// contents stay still after select rises until the next frame clocks
	assign frame = shift;
	assign frame_full = (count == FULL_COUNT);

	shift_in_a: assert property (@(posedge sclk) disable iff (cs_n)
		1'b1 |=> shift == {$past(shift[FRAME_BITS-2:0]), $past(sdata)})
		else $error("shift register did not take the data bit");

endmodule : serial_frame_shifter

`default_nettype wire

// File: shared/dac_link_pkg.sv
// constants and carrier types for the dual converter serial load block
// assumes a 100 MHz bus clock and a host-driven shift clock of at most 25 MHz
package dac_link_pkg;

	localparam int FRAME_BITS = 16;
	localparam int DATA_BITS = 8;
	localparam int ADDR_BITS = 4;
	localparam logic [4:0] FULL_COUNT = 5'h10;

	// serial link timing
	localparam int SCLK_MAX_MHZ = 25;
	localparam int ACLK_MHZ = 100;
	localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
	localparam int SCLK_MIN_PERIOD_CYC = (SCLK_MIN_PERIOD_NS * ACLK_MHZ + 999) / 1000;

	// register offsets (byte addresses)
	localparam logic [ADDR_BITS-1:0] CONTROL_OFFSET = 4'h0;
	localparam logic [ADDR_BITS-1:0] STATUS_OFFSET = 4'h4;
	localparam logic [ADDR_BITS-1:0] COUNT_OFFSET = 4'h8;
	localparam logic [ADDR_BITS-1:0] FRAME_OFFSET = 4'hc;

	// field positions
	localparam int HOLD_BIT = 0;
	localparam int STATUS_DAC_B_POS = 8;
	localparam int STATUS_SHUT_A_BIT = 16;
	localparam int STATUS_SHUT_B_BIT = 17;
	localparam int COUNT_SHORT_POS = 16;

	// reset values
	localparam logic HOLD_RESET = 1'b0;
	localparam logic [DATA_BITS-1:0] DAC_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// first bit shifted in sits at the top
	typedef struct packed {
		logic spare1;
		logic spare2;
		logic spare3;
		logic shutdown_b;
		logic shutdown_a;
		logic spare4;
		logic load_b;
		logic load_a;
		logic [DATA_BITS-1:0] data;
	} frame_type;

	typedef struct packed {
		logic [DATA_BITS-1:0] dac_a;
		logic [DATA_BITS-1:0] dac_b;
		logic shutdown_a;
		logic shutdown_b;
	} dac_state_type;

endpackage : dac_link_pkg

// File: tb/dual_dac_serial_load_control_tb.sv
// self-checking bench for the dual converter serial load block
// assumes the host link model drives the link, aclk at 100 MHz
`timescale 1ns/1ps
`default_nettype none

module dual_dac_serial_load_control_tb;
	import dac_link_pkg::*;
	typedef struct packed {
		logic [15:0] w;
		logic [7:0] a;
		logic [7:0] b;
	} row_type;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, sclk, cs_n, sdata, ref_a, ref_b;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic [7:0] out_a, out_b;
	row_type rows [7];
	int n_mismatch, total_checks, cycles, n_commit;

	dac_serial_load_control uut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .sclk(sclk), .cs_n(cs_n),
		.sdata(sdata), .channel_a_output(out_a), .channel_b_output(out_b),
		.reference_connect_a(ref_a), .reference_connect_b(ref_b)
	);
	host_link_model host (.sclk(sclk), .cs_n(cs_n), .sdata(sdata));

	always #5 aclk = ~aclk;

	// a full run needs about 2700 cycles
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			final_report();
		end
	end

	function automatic logic [15:0] mk(input logic [3:0] c, input logic [7:0] d);
		return {3'b001, c[3:2], 1'b0, c[1:0], d};
	endfunction : mk

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report

	task automatic end_test(input string s);
		$display("test %s finished", s);
	endtask : end_test

	task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : check_val

	task automatic check_resp(input string n, input logic [1:0] e, input logic [1:0] g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s response expected %h seen %h", n, e, g);
		end
	endtask : check_resp

	// entered just after a rising edge; ready and answers are sampled at the rising edge
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			done = bvalid;
			r = bresp;
		end
		bready <= 1'b0;
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			done = rvalid;
			d = rdata;
			r = rresp;
		end
		rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	task automatic rd_chk(input string n, input logic [3:0] a, input logic [31:0] e);
		axi_rd(a, rd, rs);
		check_resp(n, RESP_OKAY, rs);
		check_val(n, e, rd);
	endtask : rd_chk

	task automatic check_state(input logic [15:0] w, input logic [7:0] a, input logic [7:0] b);
		check_val("channel_a_output", 32'(w[11] ? 8'h00 : a), 32'(out_a));
		check_val("channel_b_output", 32'(w[12] ? 8'h00 : b), 32'(out_b));
		check_val("reference_connect_a", 32'(!w[11]), 32'(ref_a));
		check_val("reference_connect_b", 32'(!w[12]), 32'(ref_b));
		rd_chk("status", STATUS_OFFSET, {14'h0, w[12], w[11], b, a});
	endtask : check_state

	task automatic send_frame(input logic [15:0] w);
		host.open_frame();
		host.send_byte(w[15:8]);
		host.send_byte(w[7:0]);
		host.close_frame();
		repeat (2) @(posedge aclk);
	endtask : send_frame

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask : do_reset

	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 4'h0;
		araddr = 4'h0;
		wstrb = 4'hf;
		wdata = 32'h0;
		{n_mismatch, total_checks, cycles, n_commit} = '0;
		rows[0] = '{mk(4'h3, 8'h80), 8'h80, 8'h80};
		rows[1] = '{mk(4'h1, 8'h3c), 8'h3c, 8'h80};
		rows[2] = '{mk(4'h2, 8'ha5), 8'h3c, 8'ha5};
		rows[3] = '{mk(4'h4, 8'hff), 8'h3c, 8'ha5};
		rows[4] = '{mk(4'h9, 8'h01), 8'h01, 8'ha5};
		rows[5] = '{mk(4'hf, 8'h5a), 8'h5a, 8'h5a};
		rows[6] = '{mk(4'h0, 8'h00), 8'h5a, 8'h5a};
		do_reset();
		check_state(16'h0, 8'h00, 8'h00);
		end_test("reset");
		for (int i = 0; i < 7; i++) begin
			send_frame(rows[i].w);
			n_commit++;
			check_state(rows[i].w, rows[i].a, rows[i].b);
		end
		end_test("rows");
		// full frame held open: nothing may move before select rises
		host.open_frame();
		host.send_byte(8'h23);
		host.send_byte(8'h11);
		repeat (20) @(posedge aclk);
		check_state(16'h0, 8'h5a, 8'h5a);
		host.close_frame();
		repeat (2) @(posedge aclk);
		n_commit++;
		check_state(16'h0, 8'h11, 8'h11);
		// short frame is dropped, long frame keeps its last sixteen bits
		host.open_frame();
		host.send_byte(8'h23);
		host.close_frame();
		repeat (2) @(posedge aclk);
		check_state(16'h0, 8'h11, 8'h11);
		host.open_frame();
		host.send_byte(8'hff);
		send_frame(16'h2177);
		n_commit++;
		check_state(16'h0, 8'h77, 8'h11);
		end_test("framing");
		axi_wr(CONTROL_OFFSET, 32'h1, rs);
		check_resp("control write", RESP_OKAY, rs);
		rd_chk("control", CONTROL_OFFSET, 32'h1);
		send_frame(16'h2399);
		check_state(16'h0, 8'h77, 8'h11);
		axi_wr(CONTROL_OFFSET, 32'h0, rs);
		check_resp("control clear", RESP_OKAY, rs);
		// byte lane 0 disabled: hold bit must not move
		wstrb <= 4'he;
		axi_wr(CONTROL_OFFSET, 32'h1, rs);
		wstrb <= 4'hf;
		check_resp("masked control write", RESP_OKAY, rs);
		rd_chk("masked control", CONTROL_OFFSET, 32'h0);
		axi_wr(STATUS_OFFSET, 32'hffff_ffff, rs);
		check_resp("status write", RESP_SLVERR, rs);
		axi_wr(4'h2, 32'h1, rs);
		check_resp("unaligned write", RESP_DECERR, rs);
		rd_chk("control", CONTROL_OFFSET, 32'h0);
		axi_rd(4'h2, rd, rs);
		check_resp("unaligned read", RESP_DECERR, rs);
		check_val("unaligned read", 32'h0, rd);
		rd_chk("last frame", FRAME_OFFSET, 32'h2177);
		rd_chk("counts", COUNT_OFFSET, {16'h1, 16'(n_commit)});
		end_test("registers");
		do_reset();
		check_state(16'h0, 8'h00, 8'h00);
		rd_chk("counts after reset", COUNT_OFFSET, 32'h0);
		rd_chk("last frame after reset", FRAME_OFFSET, 32'h0);
		end_test("second reset");
		final_report();
	end
endmodule : dual_dac_serial_load_control_tb
`default_nettype wire

// File: tb/host_link_model.sv
// host side of the three-wire link: select, shift clock and serial data
// assumes the bench calls one task at a time and lets each one finish
`timescale 1ns/1ps
`default_nettype none

module host_link_model (
	output var logic sclk,
	output var logic cs_n,
	output var logic sdata
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdata = 1'b0;
		// select pulse at power-up arms the link bit counter
		#1 cs_n = 1'b0;
		#1 cs_n = 1'b1;
	end

	// 62.5 ns half period: 8 MHz, well inside the link limit
	// small offset keeps link edges off the bus clock edges
	task automatic open_frame();
		#2.5 cs_n = 1'b0;
		#62.5;
	endtask : open_frame

	// data changes on the falling edge so it is steady around the rise
	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sdata = b[i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
	endtask : send_byte

	// clock stands still between frames; released data shows the inverse
	task automatic close_frame();
		#62.5 cs_n = 1'b1;
		sdata = ~sdata;
		#125;
	endtask : close_frame
endmodule : host_link_model
`default_nettype wire
